// ### pvrp_vendor_pages.sv
// Purpose: Identification and vendor-dependent register pages behind an APB slave
// Assumes: mclk 50 MHz, rst synchronous active high, zero wait-state APB
// Notes:   Read data is captured in the setup cycle and held through the access
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pvrp_regs.svh"

module pvrp_vendor_pages #(
    parameter logic [23:0] MAKER_OUI  = 24'h5a_a5_c3, // Arbitrary value
    parameter logic [23:0] PART_IDENT = 24'h3c_96_0f  // Arbitrary value
) (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`PVRP_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      bridgeStrap,
    output pvrp_pkg::pvrp_selfid_t         selfIdReport,
    output logic      [2:0]                pageSelect
);

    // ======================================================================
    // Address decode
    // ======================================================================
    logic [3:0]       regIdx;
    logic             addrMapped;
    logic             isPaged;
    logic             setupPhase;
    logic             accessWrite;
    pvrp_pkg::pvrp_state_t stQ;
    pvrp_pkg::pvrp_state_t stD;
    logic [7:0]       readByte;

    assign regIdx      = paddr[5:2];
    assign isPaged     = regIdx >= `PVRP_IDX_PAGED_FIRST;
    assign addrMapped  = (paddr[`PVRP_ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0)
                         && (isPaged || regIdx == `PVRP_IDX_PAGE_SEL);
    assign setupPhase  = psel && !penable;
    assign accessWrite = psel && penable && pwrite;

    // ======================================================================
    // Read multiplexer
    // ======================================================================
    always_comb begin
        readByte = 8'h00;
        if (regIdx == `PVRP_IDX_PAGE_SEL) begin
            readByte = {5'h00, stQ.pageSel};
        end else if (isPaged && stQ.pageSel == `PVRP_PAGE_IDENT) begin
            case (regIdx)
                `PVRP_IDX_CONFORMANCE: readByte = `PVRP_CONFORMANCE_VAL;
                `PVRP_IDX_OUI_HI:      readByte = MAKER_OUI[23:16];
                `PVRP_IDX_OUI_MID:     readByte = MAKER_OUI[15:8];
                `PVRP_IDX_OUI_LO:      readByte = MAKER_OUI[7:0];
                `PVRP_IDX_PART_HI:     readByte = PART_IDENT[23:16];
                `PVRP_IDX_PART_MID:    readByte = PART_IDENT[15:8];
                `PVRP_IDX_PART_LO:     readByte = PART_IDENT[7:0];
                default:               readByte = 8'h00;
            endcase
        end else if (isPaged && stQ.pageSel == `PVRP_PAGE_VENDOR) begin
            case (regIdx)
                `PVRP_IDX_CTRL_SPEED:  readByte = {6'h00, stQ.ctrlSpeed};
                `PVRP_IDX_BRIDGE_CFG:  readByte = {6'h00, stQ.bridgeCap};
                default:               readByte = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        stD = stQ;
        if (setupPhase) begin
            stD.rdata  = {24'h000000, readByte};
            stD.slverr = !addrMapped;
        end
        if (accessWrite && addrMapped) begin
            if (regIdx == `PVRP_IDX_PAGE_SEL) begin
                stD.pageSel = pwdata[`PVRP_PAGE_MSB:`PVRP_PAGE_LSB];
            end else if (stQ.pageSel == `PVRP_PAGE_VENDOR) begin
                if (regIdx == `PVRP_IDX_CTRL_SPEED) begin
                    stD.ctrlSpeed = pwdata[`PVRP_FIELD_MSB:`PVRP_FIELD_LSB];
                end else if (regIdx == `PVRP_IDX_BRIDGE_CFG) begin
                    stD.bridgeCap = pwdata[`PVRP_FIELD_MSB:`PVRP_FIELD_LSB];
                end
            end
        end
    end

    // ======================================================================
    // State register; strap is sampled on every edge while reset is held
    // ======================================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            stQ.pageSel   <= `PVRP_PAGE_RESET;
            stQ.ctrlSpeed <= `PVRP_SPEED_RESET;
            stQ.bridgeCap <= bridgeStrap ? `PVRP_BRIDGE_CHANGED
                                         : `PVRP_BRIDGE_NONE;
            stQ.rdata     <= 32'h00000000;
            stQ.slverr    <= 1'b0;
        end else begin
            stQ <= stD;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign prdata     = stQ.rdata;
    assign pready     = 1'b1;
    assign pslverr    = stQ.slverr && psel && penable;
    assign pageSelect = stQ.pageSel;
    assign selfIdReport.peerAnnounce   = `PVRP_SPEED_S400;
    assign selfIdReport.nodeSpeedField = (stQ.ctrlSpeed == `PVRP_SPEED_ILLEGAL)
                                         ? `PVRP_SPEED_S400 : stQ.ctrlSpeed;
    assign selfIdReport.bridgeReport   = stQ.bridgeCap;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic pastRst;
    always_ff @(posedge mclk) begin
        pastRst <= rst;
    end

    AST_CONFORMANCE_READ: assert property (
        setupPhase && !pwrite && addrMapped && regIdx == `PVRP_IDX_CONFORMANCE
        && stQ.pageSel == `PVRP_PAGE_IDENT |=> prdata == 32'h00000001)
        else $error("Conformance level read wrong");

    AST_OUI_HI_READ: assert property (
        setupPhase && addrMapped && regIdx == `PVRP_IDX_OUI_HI
        && stQ.pageSel == `PVRP_PAGE_IDENT |=> prdata[7:0] == MAKER_OUI[23:16])
        else $error("Maker identifier high byte wrong");

    AST_PART_HI_READ: assert property (
        setupPhase && addrMapped && regIdx == `PVRP_IDX_PART_HI
        && stQ.pageSel == `PVRP_PAGE_IDENT |=> prdata[7:0] == PART_IDENT[23:16])
        else $error("Product identifier high byte wrong");

    AST_PAGE_GATING: assert property (
        setupPhase && addrMapped && regIdx == `PVRP_IDX_CONFORMANCE
        && stQ.pageSel != `PVRP_PAGE_IDENT && stQ.pageSel != `PVRP_PAGE_VENDOR
        |=> prdata == 32'h00000000)
        else $error("Paged data visible with no page selected");

    AST_SPEED_READBACK: assert property (
        setupPhase && addrMapped && regIdx == `PVRP_IDX_CTRL_SPEED
        && stQ.pageSel == `PVRP_PAGE_VENDOR
        |=> prdata == {30'h00000000, $past(stQ.ctrlSpeed)})
        else $error("Controller speed read back differs from write");

    AST_ILLEGAL_SPEED: assert property (
        accessWrite && addrMapped && regIdx == `PVRP_IDX_CTRL_SPEED
        && stQ.pageSel == `PVRP_PAGE_VENDOR && pwdata[1:0] == 2'h3
        |=> stQ.ctrlSpeed == 2'h3 && selfIdReport.nodeSpeedField == 2'h2)
        else $error("Illegal speed not substituted in self-ID");

    AST_SPEED_COPY: assert property (
        stQ.ctrlSpeed != 2'h3 |-> selfIdReport.nodeSpeedField == stQ.ctrlSpeed)
        else $error("Node speed field not copied");

    AST_PEER_S400: assert property (
        $changed(stQ.ctrlSpeed) |-> selfIdReport.peerAnnounce == 2'h2 [*2])
        else $error("Peer announcement not S400");

    AST_RESET_SPEED: assert property (
        pastRst |-> stQ.ctrlSpeed == 2'h2)
        else $error("Controller speed not 10b after reset");

    AST_STRAP_LOAD: assert property (
        pastRst |-> selfIdReport.bridgeReport == ($past(bridgeStrap) ? 2'h3 : 2'h0))
        else $error("Bridge strap not loaded");

    AST_BRIDGE_WRITE: assert property (
        accessWrite && addrMapped && regIdx == `PVRP_IDX_BRIDGE_CFG
        && stQ.pageSel == `PVRP_PAGE_VENDOR
        |=> selfIdReport.bridgeReport == $past(pwdata[1:0]))
        else $error("Bridge write not reported in self-ID");

    AST_RESERVED_READ: assert property (
        setupPhase && addrMapped && regIdx >= 4'ha
        && stQ.pageSel == `PVRP_PAGE_VENDOR |=> prdata == 32'h00000000)
        else $error("Reserved location reads nonzero");

    AST_RESERVED_WRITE: assert property (
        accessWrite && regIdx >= 4'ha |=> $stable(stQ.ctrlSpeed) && $stable(stQ.bridgeCap))
        else $error("Reserved write changed state");

    COV_PAGE_IDENT: cover property (accessWrite && addrMapped
        && regIdx == `PVRP_IDX_PAGE_SEL && pwdata[2:0] == 3'h1);
    COV_PAGE_VENDOR: cover property (accessWrite && addrMapped
        && regIdx == `PVRP_IDX_PAGE_SEL && pwdata[2:0] == 3'h7);
    COV_ILLEGAL_SPEED: cover property (stQ.ctrlSpeed == 2'h3);
    COV_UNMAPPED: cover property (pslverr);

endmodule // pvrp_vendor_pages

`default_nettype wire

// ### pvrp_regs.svh
// Purpose: Register map, field positions, reset values for the paged vendor registers
// Assumes: APB word addressing, byte address = index * 4
// Notes:   Definitions only
`ifndef PVRP_REGS_SVH
`define PVRP_REGS_SVH

// ==========================================================================
// Register indices (byte address is index * 4)
// ==========================================================================
`define PVRP_IDX_PAGE_SEL        4'h7
`define PVRP_IDX_CONFORMANCE     4'h8
`define PVRP_IDX_ID_RSVD         4'h9
`define PVRP_IDX_OUI_HI          4'ha
`define PVRP_IDX_OUI_MID         4'hb
`define PVRP_IDX_OUI_LO          4'hc
`define PVRP_IDX_PART_HI         4'hd
`define PVRP_IDX_PART_MID        4'he
`define PVRP_IDX_PART_LO         4'hf
`define PVRP_IDX_CTRL_SPEED      4'h8
`define PVRP_IDX_BRIDGE_CFG      4'h9
`define PVRP_IDX_PAGED_FIRST     4'h8

// ==========================================================================
// Page codes and field values
// ==========================================================================
`define PVRP_PAGE_IDENT          3'h1
`define PVRP_PAGE_VENDOR         3'h7
`define PVRP_PAGE_RESET          3'h0
`define PVRP_PAGE_LSB            0
`define PVRP_PAGE_MSB            2
`define PVRP_FIELD_LSB           0
`define PVRP_FIELD_MSB           1
`define PVRP_CONFORMANCE_VAL     8'h01
`define PVRP_SPEED_S100          2'h0
`define PVRP_SPEED_S200          2'h1
`define PVRP_SPEED_S400          2'h2
`define PVRP_SPEED_ILLEGAL       2'h3
`define PVRP_SPEED_RESET         2'h2
`define PVRP_BRIDGE_NONE         2'h0
`define PVRP_BRIDGE_CHANGED      2'h3
`define PVRP_ADDR_W              12

`endif

// ### pvrp_pkg.sv
// Purpose: Types shared by the paged vendor register bank
// Assumes: Constants live in pvrp_regs.svh
// Notes:   Types only
`default_nettype none

package pvrp_pkg;

    // ======================================================================
    // Self-ID report carried to the packet builder
    // ======================================================================
    typedef struct packed {
        logic [1:0] peerAnnounce;
        logic [1:0] nodeSpeedField;
        logic [1:0] bridgeReport;
    } pvrp_selfid_t;

    // ======================================================================
    // Whole register state of the bank
    // ======================================================================
    typedef struct packed {
        logic [2:0]  pageSel;
        logic [1:0]  ctrlSpeed;
        logic [1:0]  bridgeCap;
        logic [31:0] rdata;
        logic        slverr;
    } pvrp_state_t;

endpackage

`default_nettype wire

// ### pvrp_link_model.sv
// Purpose: Link controller model issuing register accesses over APB
// Assumes: Slave may insert wait states; answer sampled at rising edges only
// Notes:   Address and write data are zero before the first transfer, then inverted while the bus is idle
`timescale 1ns/1ps
`default_nettype none
`include "pvrp_regs.svh"

module pvrp_link_model (
    input  wire logic                    mclk,
    output logic                         psel,
    output logic                         penable,
    output logic                         pwrite,
    output logic [`PVRP_ADDR_W-1:0]      paddr,
    output logic [31:0]                  pwdata,
    input  wire logic [31:0]             prdata,
    input  wire logic                    pready,
    input  wire logic                    pslverr
);
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = '0;
        pwdata  = '0;
    end

    // ========
    // One transfer: setup, then access held until pready
    task automatic xfer(input logic wr, input logic [`PVRP_ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) @(posedge mclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        paddr   <= ~a;
        pwdata  <= ~wd;
    endtask
endmodule // pvrp_link_model

`default_nettype wire

// ### phy_vendor_register_pages_tb.sv
// Purpose: Self-checking bench for the paged vendor registers
// Assumes: Zero or more wait states, byte address = index * 4
// Notes:   Identifier values below are arbitrary
`timescale 1ns/1ps
`default_nettype none
`include "pvrp_regs.svh"

module phy_vendor_register_pages_tb;
    localparam logic [23:0] OUI  = 24'h9e_17_4b; // Arbitrary value
    localparam logic [23:0] PART = 24'h61_d8_2a; // Arbitrary value
    localparam logic [63:0] IDT  = {8'h01, 8'h00, OUI, PART};
    logic                          mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic                          bridgeStrap, err;
    logic [`PVRP_ADDR_W-1:0]       paddr;
    logic [31:0]                   pwdata, prdata, rd;
    logic [2:0]                    pageSelect;
    pvrp_pkg::pvrp_selfid_t        selfIdReport;
    int                            failures = 0;
    int                            comparisons = 0;

    pvrp_vendor_pages #(.MAKER_OUI(OUI), .PART_IDENT(PART)) u_pvrp_vendor_pages (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bridgeStrap(bridgeStrap), .selfIdReport(selfIdReport),
        .pageSelect(pageSelect));

    pvrp_link_model u_pvrp_link_model (
        .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    // ========
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_pvrp_link_model.xfer(1'h1, a, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        u_pvrp_link_model.xfer(1'h0, a, 32'h0, rd, err);
        check(what, rd, exp);
    endtask

    task automatic do_reset(input logic strap);
        rst         <= 1'h1;
        bridgeStrap <= strap;
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end

    // ========
    // Tests
    initial begin
        rst         = 1'h1;
        bridgeStrap = 1'h1;
        do_reset(1'h1);
        check("pageSelect", 32'(pageSelect), 32'h0);
        check("selfid", 32'(selfIdReport), 32'h2b);
        $display("test reset done");

        rdchk("page0 paged", 12'h020, 32'h0);
        wr(12'h01c, 32'h1);
        rdchk("pageSel", 12'h01c, 32'h1);
        wr(12'h020, 32'hff);
        wr(12'h02c, 32'hff);
        for (int i = 8; i < 16; i++) begin
            rdchk("id page", 12'(i * 4), 32'(IDT[8 * (15 - i) +: 8]));
        end
        $display("test identification page done");

        wr(12'h01c, 32'h7);
        @(posedge mclk);
        check("pageSelect", 32'(pageSelect), 32'h7);
        for (int v = 0; v < 4; v++) begin
            wr(12'h020, 32'(v));
            wr(12'h024, 32'(v));
            @(posedge mclk);
            rdchk("speed", 12'h020, 32'(v));
            rdchk("bridge", 12'h024, 32'(v));
            check("selfid", 32'(selfIdReport), {26'h0, 2'h2, (v == 3) ? 2'h2 : 2'(v), 2'(v)});
        end
        for (int i = 10; i < 16; i++) begin
            wr(12'(i * 4), 32'hff);
            rdchk("test rsvd", 12'(i * 4), 32'h0);
        end
        $display("test vendor page done");

        wr(12'h01c, 32'h2);
        rdchk("page2 paged", 12'h020, 32'h0);
        check("slverr", 32'(err), 32'h0);
        rdchk("unmapped", 12'h004, 32'h0);
        check("slverr", 32'(err), 32'h1);
        $display("test page and unmapped done");

        do_reset(1'h0);
        check("selfid", 32'(selfIdReport), 32'h28);
        check("pageSelect", 32'(pageSelect), 32'h0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // phy_vendor_register_pages_tb

`default_nettype wire
